// ==== tmz_cfg.svh ====
// Constants of the eight-bit timer/counter: reset values, counts and phase codes
`ifndef TMZ_CFG_SVH
`define TMZ_CFG_SVH

// Reset values
`define TMZ_COUNT_RST    8'h00
`define TMZ_PSC_RST      8'h00
`define TMZ_INHIBIT_RST  2'h0
`define TMZ_PHASE_RST    2'h0

// Count register rollover point
`define TMZ_COUNT_MAX    8'hFF

// Instruction cycles without increment after a count write
`define TMZ_INHIBIT_CYC  2'h2

// Highest prescale rate code; rate n divides by two to the n plus one
`define TMZ_RATE_MAX     3'h7

// Clock cycles per instruction cycle (phases Q1 to Q4)
`define TMZ_CLK_PER_INSTR 4

`endif

// ==== tmz_pkg.sv ====
// Types shared by the eight-bit timer/counter
package tmz_pkg;

  // Phase of the instruction cycle; one clock per phase
  typedef enum logic [1:0] {
    TMZ_Q1 = 2'b00,
    TMZ_Q2 = 2'b01,
    TMZ_Q3 = 2'b10,
    TMZ_Q4 = 2'b11
  } tmz_phase_t;

  typedef logic [2:0] tmz_rate_t;

endpackage

// ==== tmz_sync.sv ====
// Three-stage synchroniser with agreement filter for an asynchronous level
`timescale 1ns/1ps
`default_nettype none

module tmz_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output var  logic level
);

  logic [2:0] stage_r;
  logic [2:0] stage_nxt;
  logic       level_r;
  logic       level_nxt;

  always_comb begin
    stage_nxt = {stage_r[1:0], async_in};
    level_nxt = level_r;
    // Stage 0 feeds only stage 1; the level moves once stages 1 and 2 agree
    if (stage_r[1] == stage_r[2]) begin
      level_nxt = stage_r[2];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage_r <= 3'h0;
      level_r <= 1'b0;
    end else begin
      stage_r <= stage_nxt;
      level_r <= level_nxt;
    end
  end

  assign level = level_r;

endmodule

`default_nettype wire

// ==== tmz_timer.sv ====
// Eight-bit timer/counter with prescaler, overflow flag and interrupt request
//
// How it works
// - Timer mode without prescaler adds one to the count each instruction cycle.
// - A count write blocks incrementing for the next two instruction cycles.
// - Counter mode adds one on each chosen edge of the selected external source.
// - External-source select picks the count pin (0) or cap-sense oscillator (1).
// - Source-edge select picks rising (0) or falling (1) edge as the counting edge.
// - Own prescaler, separate from the watchdog one, is used only while bypass is clear.
// - Eight prescale ratios from 1:2 to 1:256 picked by the three-bit rate field.
// - Bypass set gives 1:1, one increment per source event.
// - Prescaler count is hidden from software and cleared by every count write.
// - Rollover from FFh to 00h always sets the overflow flag, enable or not.
// - The overflow flag stays set until software clears it.
// - Interrupt is requested only when flag and overflow enable are both set.
// - Overflow cannot wake the processor since nothing counts during sleep.
// - During sleep counting stops and the count keeps its value.
// - Counter-mode increments are taken only at the Q2 and Q4 phases.
// - Overflow is given as a signal the companion timer can use for gating.
`timescale 1ns/1ps
`default_nettype none
`include "tmz_cfg.svh"

module tmz_timer (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             sleep,
  input  wire logic             clock_source_select,
  input  wire logic             external_source_select,
  input  wire logic             source_edge_select,
  input  wire logic             prescaler_bypass,
  input  wire tmz_pkg::tmz_rate_t prescale_rate,
  input  wire logic             overflow_irq_enable,
  input  wire logic             count_wr,
  input  wire logic [7:0]       count_wdata,
  input  wire logic             flag_clear,
  input  wire logic             count_input_pin,
  input  wire logic             cap_sense_osc_clock,
  output var  logic [7:0]       count_register,
  output var  logic             overflow_flag,
  output var  logic             irq_request,
  output var  logic             overflow_gate
);
  import tmz_pkg::*;

  // Mask of the prescaler bits that must all be ones for a carry out
  function automatic logic [7:0] rate_mask(input tmz_rate_t rate);
    rate_mask = 8'hFF >> (`TMZ_RATE_MAX - rate);
  endfunction

  // Synchronised external sources
  logic pin_level;
  logic cap_level;

  tmz_sync u_pin_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (count_input_pin),
    .level    (pin_level)
  );

  tmz_sync u_cap_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (cap_sense_osc_clock),
    .level    (cap_level)
  );

  // Instruction-cycle phase
  tmz_phase_t phase_r;
  tmz_phase_t phase_nxt;

  always_comb begin
    phase_nxt = phase_r;
    if (!sleep) begin
      case (phase_r)
        TMZ_Q1:  phase_nxt = TMZ_Q2;
        TMZ_Q2:  phase_nxt = TMZ_Q3;
        TMZ_Q3:  phase_nxt = TMZ_Q4;
        TMZ_Q4:  phase_nxt = TMZ_Q1;
        default: phase_nxt = TMZ_Q1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_r <= tmz_phase_t'(`TMZ_PHASE_RST);
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // Source selection and edge detection
  logic src_level;
  logic src_prev_r;
  logic src_prev_nxt;
  logic edge_evt;
  logic instr_end;
  logic src_evt;

  always_comb begin
    src_level    = external_source_select ? cap_level : pin_level;
    src_prev_nxt = src_level;
    // Edge select high gives high-to-low counting
    edge_evt     = source_edge_select ? (src_prev_r & ~src_level)
                                      : (~src_prev_r & src_level);
    instr_end    = (phase_r == TMZ_Q4);
    // Timer mode counts instruction cycles, counter mode counts edges
    src_evt      = !sleep && (clock_source_select ? edge_evt : instr_end);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_prev_r <= 1'b0;
    end else begin
      src_prev_r <= src_prev_nxt;
    end
  end

  // Prescaler, pending increment and write inhibit
  logic [7:0] psc_r;
  logic [7:0] psc_nxt;
  logic       pend_r;
  logic       pend_nxt;
  logic [1:0] inhibit_r;
  logic [1:0] inhibit_nxt;
  logic       tick;
  logic       sample_pt;
  logic       pend_any;
  logic       inc_fire;

  always_comb begin
    // Carry out of the selected prescaler stage, or every event when bypassed
    tick = src_evt && (prescaler_bypass ||
           ((psc_r & rate_mask(prescale_rate)) == rate_mask(prescale_rate)));
    sample_pt = !sleep && (phase_r == TMZ_Q2 || phase_r == TMZ_Q4);
    pend_any  = pend_r || tick;
    inc_fire  = sample_pt && pend_any && (inhibit_r == `TMZ_INHIBIT_RST) && !count_wr;

    psc_nxt = psc_r;
    if (count_wr) begin
      psc_nxt = `TMZ_PSC_RST;
    end else if (src_evt && !prescaler_bypass) begin
      psc_nxt = psc_r + 8'h01;
    end

    pend_nxt = pend_any;
    if (count_wr || sample_pt) begin
      // Events taken while inhibited are dropped, not deferred
      pend_nxt = 1'b0;
    end

    inhibit_nxt = inhibit_r;
    if (count_wr) begin
      inhibit_nxt = `TMZ_INHIBIT_CYC;
    end else if (instr_end && !sleep && inhibit_r != `TMZ_INHIBIT_RST) begin
      inhibit_nxt = inhibit_r - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      psc_r     <= `TMZ_PSC_RST;
      pend_r    <= 1'b0;
      inhibit_r <= `TMZ_INHIBIT_RST;
    end else begin
      psc_r     <= psc_nxt;
      pend_r    <= pend_nxt;
      inhibit_r <= inhibit_nxt;
    end
  end

  // Count, overflow flag and outputs
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic       flag_r;
  logic       flag_nxt;
  logic       irq_r;
  logic       irq_nxt;
  logic       gate_r;
  logic       gate_nxt;
  logic       ovf;

  always_comb begin
    ovf       = inc_fire && (count_r == `TMZ_COUNT_MAX);
    count_nxt = count_r;
    if (count_wr) begin
      count_nxt = count_wdata;
    end else if (inc_fire) begin
      count_nxt = count_r + 8'h01;
    end
    // Overflow wins over a clear in the same cycle
    flag_nxt = flag_r;
    if (ovf) begin
      flag_nxt = 1'b1;
    end else if (flag_clear) begin
      flag_nxt = 1'b0;
    end
    irq_nxt  = flag_nxt && overflow_irq_enable;
    gate_nxt = ovf;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_r <= `TMZ_COUNT_RST;
      flag_r  <= 1'b0;
      irq_r   <= 1'b0;
      gate_r  <= 1'b0;
    end else begin
      count_r <= count_nxt;
      flag_r  <= flag_nxt;
      irq_r   <= irq_nxt;
      gate_r  <= gate_nxt;
    end
  end

  // Reads see the live count with no side effect
  assign count_register = count_r;
  assign overflow_flag  = flag_r;
  assign irq_request    = irq_r;
  assign overflow_gate  = gate_r;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_write_quiet;
    count_wr ##1 (!count_wr)[*4];
  endsequence

  a_write_inhibit: assert property (
    s_write_quiet |-> count_r == $past(count_wdata, 4)
  ) else $error("count moved during write inhibit");

  a_timer_rate: assert property (
    (instr_end && !clock_source_select && prescaler_bypass && !sleep && !count_wr
     && inhibit_r == 2'h0) |=> count_r == $past(count_r) + 8'h01
  ) else $error("timer mode missed an instruction cycle");

  a_overflow_sets: assert property (
    (inc_fire && count_r == 8'hFF) |=> (flag_r && count_r == 8'h00 && gate_r)
  ) else $error("rollover did not set the flag");

  a_flag_sticky: assert property (
    (flag_r && !flag_clear) |=> flag_r
  ) else $error("overflow flag dropped without a clear");

  a_irq_gating: assert property (
    irq_r == (flag_r && $past(overflow_irq_enable))
  ) else $error("interrupt request not flag and enable");

  a_sleep_freeze: assert property (
    (sleep && !count_wr) |=> $stable(count_r) && $stable(psc_r)
  ) else $error("count moved in sleep");

  a_sleep_noflag: assert property (
    (sleep && !flag_r) |=> !flag_r
  ) else $error("flag set during sleep");

  a_prescale_carry: assert property (
    (tick && !prescaler_bypass && !count_wr) |=>
      (psc_r & rate_mask($past(prescale_rate))) == 8'h00
  ) else $error("prescaler stages did not wrap on a tick");

  a_bypass_rate: assert property (
    (prescaler_bypass && src_evt) |-> tick
  ) else $error("bypass lost a source event");

  a_psc_clear: assert property (
    count_wr |=> psc_r == 8'h00 && !pend_r
  ) else $error("count write left prescaler state");

  a_sample_phase: assert property (
    inc_fire |-> (phase_r == TMZ_Q2 || phase_r == TMZ_Q4)
  ) else $error("increment outside Q2 or Q4");

  a_gate_pulse: assert property (
    gate_r |-> $past(count_r) == 8'hFF && count_r == 8'h00
  ) else $error("gate pulse without rollover");

  // Flag priority, load and quiet-state checks
  a_set_wins: assert property (
    (ovf && flag_clear) |=> flag_r
  ) else $error("clear beat a rollover in the same cycle");

  a_write_load: assert property (
    count_wr |=> count_r == $past(count_wdata)
  ) else $error("count write did not load the data");

  a_count_hold: assert property (
    (!count_wr && !inc_fire) |=> $stable(count_r)
  ) else $error("count moved without write or increment");

  a_psc_idle: assert property (
    (prescaler_bypass && !count_wr) |=> $stable(psc_r)
  ) else $error("bypassed prescaler kept counting");

endmodule

`default_nettype wire

// ==== tmz_src_model.sv ====
// External count sources: input pin and cap-sense oscillator
`timescale 1ns/1ps
`default_nettype none

module tmz_src_model (
  input  wire logic clk,
  output var  logic count_input_pin,
  output var  logic cap_sense_osc_clock
);
  initial begin
    count_input_pin     = 1'b0;
    cap_sense_osc_clock = 1'b0;
  end

  // Each level is held 8 clocks, longer than the synchroniser needs
  task automatic put(input logic sel, input logic v);
    @(posedge clk);
    if (sel) cap_sense_osc_clock <= v;
    else count_input_pin <= v;
    repeat (8) @(posedge clk);
  endtask
endmodule

`default_nettype wire

// ==== tb_tmz_timer.sv ====
// Self-checking bench of the eight-bit timer/counter
`timescale 1ns/1ps
`default_nettype none

module tb_tmz_timer;
  import tmz_pkg::*;
  logic       clk, rst_n, sleep, clock_source_select, external_source_select;
  logic       source_edge_select, prescaler_bypass, overflow_irq_enable;
  logic       count_wr, flag_clear, count_input_pin, cap_sense_osc_clock;
  logic       overflow_flag, irq_request, overflow_gate;
  logic [7:0] count_wdata, count_register, v;
  tmz_rate_t  prescale_rate;
  int         bad_count = 0;
  int         comparisons = 0;
  int         gates = 0;
  int         k;

  tmz_timer tmz_timer_i (.clk, .rst_n, .sleep, .clock_source_select,
    .external_source_select, .source_edge_select, .prescaler_bypass, .prescale_rate,
    .overflow_irq_enable, .count_wr, .count_wdata, .flag_clear, .count_input_pin,
    .cap_sense_osc_clock, .count_register, .overflow_flag, .irq_request, .overflow_gate);
  tmz_src_model tmz_src_model_i (.clk, .count_input_pin, .cap_sense_osc_clock);

  initial clk = 1'b0;
  always #25 clk = ~clk;
  always @(posedge clk) if (overflow_gate === 1'b1) gates++;

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    count_wr    <= 1'b1;
    count_wdata <= d;
    @(posedge clk);
    count_wr <= 1'b0;
    #1;
  endtask

  // Waits for a count change, then expects exactly one step every p clocks
  task automatic rate_chk(input int p);
    v = count_register;
    k = 0;
    while (count_register === v && k < 1100) begin
      tick(1);
      k++;
    end
    v = count_register;
    tick(2 * p - 1);
    check("step one", count_register, v + 8'h01);
    tick(1);
    check("step two", count_register, v + 8'h02);
  endtask

  task automatic t_timer;
    @(posedge clk);
    clock_source_select <= 1'b0;
    prescaler_bypass    <= 1'b1;
    wr(8'h5A);
    tick(7);
    check("held", count_register, 8'h5A);
    k = 7;
    while (count_register === 8'h5A && k < 20) begin
      tick(1);
      k++;
    end
    check("first", count_register, 8'h5B);
    check("inhibit span", 8'(k >= 8 && k <= 14), 8'h01);
    rate_chk(4);
    $display("test timer done");
  endtask

  task automatic t_prescale;
    for (int n = 0; n < 8; n++) begin
      @(posedge clk);
      prescaler_bypass <= 1'b0;
      prescale_rate    <= tmz_rate_t'(n);
      wr(8'h00);
      rate_chk(4 << (n + 1));
    end
    $display("test prescale done");
  endtask

  task automatic t_overflow;
    @(posedge clk);
    prescaler_bypass    <= 1'b1;
    overflow_irq_enable <= 1'b0;
    wr(8'hFD);
    gates = 0;
    k = 0;
    while (overflow_flag !== 1'b1 && k < 60) begin
      tick(1);
      k++;
    end
    check("wrap", count_register, 8'h00);
    check("irq off", irq_request, 1'b0);
    tick(20);
    check("gate", 8'(gates), 8'h01);
    check("sticky", overflow_flag, 1'b1);
    @(posedge clk);
    overflow_irq_enable <= 1'b1;
    tick(2);
    check("irq on", irq_request, 1'b1);
    @(posedge clk);
    flag_clear <= 1'b1;
    @(posedge clk);
    flag_clear <= 1'b0;
    tick(2);
    check("cleared", overflow_flag, 1'b0);
    check("irq gone", irq_request, 1'b0);
    $display("test overflow done");
  endtask

  // A write of FF in sleep must not roll over until the core wakes
  task automatic t_sleep;
    @(posedge clk);
    sleep <= 1'b1;
    wr(8'hFF);
    tick(40);
    check("frozen", count_register, 8'hFF);
    check("no wake flag", overflow_flag, 1'b0);
    @(posedge clk);
    sleep <= 1'b0;
    tick(16);
    check("resumed", 8'(count_register < 8'h02), 8'h01);
    check("late flag", overflow_flag, 1'b1);
    $display("test sleep done");
  endtask

  // Clear held across a rollover: the set wins for that one cycle
  task automatic t_clear_race;
    @(posedge clk);
    clock_source_select <= 1'b0;
    prescaler_bypass    <= 1'b1;
    flag_clear          <= 1'b1;
    wr(8'hFE);
    k = 0;
    while (count_register !== 8'h00 && k < 60) begin
      tick(1);
      k++;
    end
    check("set wins", overflow_flag, 1'b1);
    @(posedge clk);
    flag_clear <= 1'b0;
    tick(1);
    check("clear held", overflow_flag, 1'b0);
    $display("test clear race done");
  endtask

  task automatic t_counter;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      clock_source_select    <= 1'b1;
      external_source_select <= m[0];
      source_edge_select     <= m[1];
      wr(8'h00);
      tick(16);
      repeat (3) begin
        tmz_src_model_i.put(m[0], 1'b1);
        tmz_src_model_i.put(m[0], 1'b0);
      end
      check("pulses", count_register, 8'h03);
      tmz_src_model_i.put(!m[0], 1'b1);
      tmz_src_model_i.put(!m[0], 1'b0);
      check("other source", count_register, 8'h03);
      tmz_src_model_i.put(m[0], 1'b1);
      check("edge", count_register, m[1] ? 8'h03 : 8'h04);
      tmz_src_model_i.put(m[0], 1'b0);
      check("after edge", count_register, 8'h04);
    end
    $display("test counter done");
  endtask

  // Counter mode through the 1:2 prescaler, falling edges of the cap-sense source
  task automatic t_counter_psc;
    @(posedge clk);
    prescaler_bypass <= 1'b0;
    prescale_rate    <= 3'h0;
    wr(8'h00);
    tick(16);
    repeat (4) begin
      tmz_src_model_i.put(1'b1, 1'b1);
      tmz_src_model_i.put(1'b1, 1'b0);
    end
    check("prescaled pulses", count_register, 8'h02);
    $display("test counter prescale done");
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    {rst_n, sleep, clock_source_select, external_source_select} = 4'h0;
    {source_edge_select, prescaler_bypass, overflow_irq_enable} = 3'h0;
    {count_wr, flag_clear, prescale_rate, count_wdata} = 13'h0000;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    check("reset count", count_register, 8'h00);
    check("reset flag", overflow_flag, 1'b0);
    t_timer;
    t_prescale;
    t_overflow;
    t_sleep;
    t_clear_race;
    t_counter;
    t_counter_psc;
    tally_and_finish;
  end

  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    tally_and_finish;
  end
endmodule

`default_nettype wire
